// ---- hpsel_top.sv ----
`default_nettype none
module hpsel_top
  import hpsel_pkg::*;
#(
  parameter int unsigned EDGES = SCK_EDGES_MIN // Edges for SPI
) (
  input wire logic i_clk_sys, // System clock, 125 MHz
  input wire logic i_reset, // Asynchronous reset, active high
  input wire logic i_soft_reset, // Soft reset pulse, system clock
  input wire logic i_sck, // Serial clock pin, link clock too
  input wire logic i_csb_n, // Chip select pin, active low
  input wire logic i_sda, // Serial data pin, input side
  output logic o_mode_i2c, // Port answers as I2C target
  output logic o_mode_i3c, // Port answers as I3C SDR target
  output logic o_mode_spi, // Port answers as SPI target
  output logic o_i2c_i3c_en, // I2C/I3C handling enabled
  output logic o_spi_data_invalid, // Read data must be discarded
  output logic o_sda_oe // Data drive enable, never here
);
  // ==========================================================
  // Link-domain edge counting
  // ==========================================================
  logic frame_tog; // Toggle from the link domain
  hpsel_link_cnt #(.EDGES(EDGES)) u_link (
    .i_sck(i_sck),
    .i_csb_n(i_csb_n),
    .i_reset(i_reset),
    .o_frame_toggle(frame_tog)
  );

  // ==========================================================
  // Three-flop synchronisers for pins and the toggle
  // ==========================================================
  logic [2:0] csb_sync_reg; // Chip select stages
  logic [2:0] scl_sync_reg; // Serial clock stages
  logic [2:0] sda_sync_reg; // Serial data stages
  logic [2:0] tog_sync_reg; // Toggle stages
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      csb_sync_reg <= {3{PIN_IDLE}};
      scl_sync_reg <= {3{PIN_IDLE}};
      sda_sync_reg <= {3{PIN_IDLE}};
      tog_sync_reg <= 3'h0;
    end else begin
      csb_sync_reg <= {csb_sync_reg[1:0], i_csb_n};
      scl_sync_reg <= {scl_sync_reg[1:0], i_sck};
      sda_sync_reg <= {sda_sync_reg[1:0], i_sda};
      tog_sync_reg <= {tog_sync_reg[1:0], frame_tog};
    end
  end

  // A change counts only once stages two and three agree
  logic csb_lvl_reg, scl_lvl_reg, sda_lvl_reg, tog_lvl_reg;
  logic csb_ok, scl_ok, sda_ok, tog_ok; // Stages agree
  assign csb_ok = csb_sync_reg[1] == csb_sync_reg[2];
  assign scl_ok = scl_sync_reg[1] == scl_sync_reg[2];
  assign sda_ok = sda_sync_reg[1] == sda_sync_reg[2];
  assign tog_ok = tog_sync_reg[1] == tog_sync_reg[2];
  logic csb_fall, csb_rise, scl_rise, sda_fall, tog_evt;
  assign csb_fall = csb_ok & csb_lvl_reg & ~csb_sync_reg[2];
  assign csb_rise = csb_ok & ~csb_lvl_reg & csb_sync_reg[2];
  assign scl_rise = scl_ok & ~scl_lvl_reg & scl_sync_reg[2];
  assign sda_fall = sda_ok & sda_lvl_reg & ~sda_sync_reg[2];
  assign tog_evt = tog_ok & (tog_lvl_reg != tog_sync_reg[2]);

  // Filtered pin levels
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      csb_lvl_reg <= PIN_IDLE;
      scl_lvl_reg <= PIN_IDLE;
      sda_lvl_reg <= PIN_IDLE;
      tog_lvl_reg <= 1'b0;
    end else begin
      csb_lvl_reg <= csb_ok ? csb_sync_reg[2] : csb_lvl_reg;
      scl_lvl_reg <= scl_ok ? scl_sync_reg[2] : scl_lvl_reg;
      sda_lvl_reg <= sda_ok ? sda_sync_reg[2] : sda_lvl_reg;
      tog_lvl_reg <= tog_ok ? tog_sync_reg[2] : tog_lvl_reg;
    end
  end

  // ==========================================================
  // Frame quota flag: set by the link event, cleared at frame
  // start; the set wins so a late edge is never lost
  // ==========================================================
  logic quota_reg; // Current frame held enough edges
  logic quota_next;
  assign quota_next = tog_evt | (quota_reg & ~csb_fall);
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      quota_reg <= 1'b0;
    end else begin
      quota_reg <= quota_next;
    end
  end

  // ==========================================================
  // Address watcher: start, then seven bits on rising clock.
  // Only sampling, no start is ever generated here.
  // ==========================================================
  hpsel_mode_t mode_reg, mode_next; // Selected protocol
  logic [6:0] addr_reg; // Shifted address bits
  logic [3:0] bit_cnt_reg; // Address bits taken
  logic watch_reg; // Inside an address phase
  logic start_w, bit_w, addr_hit; // Decode terms
  // Open-drain timing of every I2C speed class is far slower
  // than the sampling clock, so one detector serves them all
  assign start_w = scl_lvl_reg & sda_fall;
  assign bit_w = watch_reg & scl_rise;
  assign addr_hit = bit_w & (bit_cnt_reg == ADDR_BITS - 4'h1) &
                    ({addr_reg[5:0], sda_lvl_reg} == BCAST_ADDR);
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      watch_reg <= 1'b0;
      bit_cnt_reg <= BIT_CNT_RST;
      addr_reg <= 7'h00;
    end else if (start_w) begin
      watch_reg <= 1'b1; // Repeated start restarts the phase
      bit_cnt_reg <= BIT_CNT_RST;
    end else if (bit_w) begin
      addr_reg <= {addr_reg[5:0], sda_lvl_reg};
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      watch_reg <= (bit_cnt_reg != ADDR_BITS - 4'h1);
    end
  end

  // ==========================================================
  // Protocol state machine
  // ==========================================================
  logic go_spi, go_i3c; // Switch conditions
  assign go_spi = csb_rise & (quota_reg | tog_evt);
  // Chip select low blocks address decoding
  assign go_i3c = addr_hit & csb_lvl_reg;
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      HPSEL_I2C: begin
        if (go_spi) begin
          mode_next = HPSEL_SPI;
        end else if (go_i3c) begin
          mode_next = HPSEL_I3C;
        end
      end
      HPSEL_I3C: begin
        if (go_spi) begin
          mode_next = HPSEL_SPI;
        end // Otherwise held
      end
      default: begin
        mode_next = HPSEL_SPI;
      end
    endcase
    if (i_soft_reset) begin
      mode_next = HPSEL_I2C;
    end
  end

  // Mode register and registered outputs
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      mode_reg <= HPSEL_I2C;
      o_mode_i2c <= 1'b1;
      o_mode_i3c <= 1'b0;
      o_mode_spi <= 1'b0;
      o_i2c_i3c_en <= 1'b1;
      o_spi_data_invalid <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      o_mode_i2c <= mode_next == HPSEL_I2C;
      o_mode_i3c <= mode_next == HPSEL_I3C;
      o_mode_spi <= mode_next == HPSEL_SPI;
      // Off as soon as chip select is seen low
      o_i2c_i3c_en <= (mode_next != HPSEL_SPI) &
                      csb_sync_reg[2] & csb_ok;
      // A frame opened outside SPI is the dummy read
      o_spi_data_invalid <= (mode_next != HPSEL_SPI) &
                            ~csb_lvl_reg;
      o_sda_oe <= 1'b0;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  a_soft_to_i2c: assert property (
    i_soft_reset |=> mode_reg == HPSEL_I2C && o_mode_i2c)
    else $error("soft reset did not select I2C");
  a_csb_low_off: assert property (
    (csb_ok && !csb_sync_reg[2]) |=> !o_i2c_i3c_en)
    else $error("I2C/I3C still enabled with chip select low");
  a_spi_on_rise: assert property (
    $rose(o_mode_spi) |-> $past(csb_rise) && !$past(i_soft_reset))
    else $error("SPI entered without chip select rising");
  a_spi_needs_quota: assert property (
    (csb_rise && !quota_reg && !tog_evt && mode_reg != HPSEL_SPI)
    |=> mode_reg != HPSEL_SPI)
    else $error("SPI entered on a short frame");
  a_dummy_invalid: assert property (
    (mode_reg == HPSEL_I2C && $fell(csb_lvl_reg)) |=>
    o_spi_data_invalid[*2])
    else $error("dummy read data not marked invalid");
  a_i3c_from_hit: assert property (
    (mode_reg == HPSEL_I2C && addr_hit && csb_lvl_reg &&
     !i_soft_reset && !csb_rise) |=> ##1 o_mode_i3c)
    else $error("broadcast address did not select I3C");
  a_i3c_held: assert property (
    (mode_reg == HPSEL_I3C && !i_soft_reset && !go_spi) |=>
    mode_reg == HPSEL_I3C)
    else $error("I3C left without reset");
  a_spi_held: assert property (
    (mode_reg == HPSEL_SPI && !i_soft_reset) |=>
    mode_reg == HPSEL_SPI)
    else $error("SPI left without reset");
  a_never_drive: assert property (
    !o_sda_oe && $onehot({o_mode_i2c, o_mode_i3c, o_mode_spi}))
    else $error("bad mode outputs or data driven");

  c_to_spi: cover property ($rose(o_mode_spi));
  c_to_i3c: cover property ($rose(o_mode_i3c));
  c_i3c_to_spi: cover property (o_mode_i3c ##[1:1000] o_mode_spi);
  c_soft_back: cover property (o_mode_spi ##1 i_soft_reset);
endmodule : hpsel_top
`default_nettype wire

// ---- hpsel_pkg.sv ----
`default_nettype none
// ==========================================================
// Shared constants of the host serial port protocol select
// ==========================================================
package hpsel_pkg;
  // Serial clock edges a chip-select low phase must hold
  localparam int unsigned SCK_EDGES_MIN = 16;
  // Width of the link-side edge counter
  localparam int unsigned SCK_CNT_W = 5;
  // Broadcast address that moves the port into I3C
  localparam logic [6:0] BCAST_ADDR = 7'h7E;
  // Address bits counted after a start condition
  localparam logic [3:0] ADDR_BITS = 4'h7;
  // Reset value of the idle bit counter
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  // Reset level of chip select, clock and data (released)
  localparam logic PIN_IDLE = 1'b1;
  // Protocol the port answers in
  typedef enum logic [1:0] {
    HPSEL_I2C,
    HPSEL_I3C,
    HPSEL_SPI
  } hpsel_mode_t;
endpackage : hpsel_pkg
`default_nettype wire

// ---- hpsel_link_cnt.sv ----
`default_nettype none
// ==========================================================
// Link side: counts serial clock edges within one frame
// ==========================================================
module hpsel_link_cnt
  import hpsel_pkg::*;
#(
  parameter int unsigned EDGES = SCK_EDGES_MIN // Edges for SPI
) (
  input wire logic i_sck, // Serial clock from the host
  input wire logic i_csb_n, // Chip select, active low
  input wire logic i_reset, // Asynchronous reset, active high
  output logic o_frame_toggle // Flips once per qualifying frame
);
  logic [SCK_CNT_W-1:0] cnt_reg; // Edges seen in this frame
  logic [SCK_CNT_W-1:0] cnt_next; // Saturating next count
  logic frame_clr; // Frame over or global reset
  logic hit_w; // This edge completes the quota
  logic tog_reg; // Event toggle towards system side

  // The clock can stand still between frames, so chip select high
  // itself clears the count; no edge after the frame is needed
  assign frame_clr = i_reset | i_csb_n;
  // Gated by chip select: bus clocks outside a frame never count,
  // even for a quota as small as one edge
  assign hit_w = ~i_csb_n & (cnt_reg == SCK_CNT_W'(EDGES - 1));
  assign cnt_next = (cnt_reg == SCK_CNT_W'(EDGES)) ? cnt_reg
                    : cnt_reg + 1'b1;

  // ==========================================================
  // Edge counter, cleared by the frame's own chip select
  // ==========================================================
  always_ff @(posedge i_sck or posedge frame_clr) begin
    if (frame_clr) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // ==========================================================
  // Toggle survives the frame end so the event is not lost
  // ==========================================================
  always_ff @(posedge i_sck or posedge i_reset) begin
    if (i_reset) begin
      tog_reg <= 1'b0;
    end else if (hit_w) begin
      tog_reg <= ~tog_reg;
    end
  end

  assign o_frame_toggle = tog_reg;
endmodule : hpsel_link_cnt
`default_nettype wire

// ---- hpsel_host_model.sv ----
`default_nettype none
// ==========================================================
// Host bus master model driving the serial pins
// ==========================================================
module hpsel_host_model (
  input wire logic i_clk_sys, // Bench clock for alignment
  output logic o_sck, // Serial clock, idles high
  output logic o_csb_n, // Chip select, active low
  output logic o_sda // Data, pull-up level when released
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pins released at start: pull-ups hold them high
  initial begin
    o_sck = 1'b1;
    o_csb_n = 1'b1;
    o_sda = 1'b1;
  end
  // Chip select edge; the lag also covers the 40 ns hold
  task automatic cs_set(input logic lvl);
    #40;
    @(negedge i_clk_sys);
    o_csb_n = lvl;
  endtask : cs_set
  // Dummy read frame, 32 ns clock only inside the frame
  task automatic sck_run(input int n, inout int seed);
    #3;
    for (int i = 0; i < n; i++) begin
      o_sck = 1'b0;
      o_sda = 1'($random(seed));
      #16 o_sck = 1'b1;
      #16;
    end
    o_sda = 1'b1;
  endtask : sck_run
  // Start, seven address bits MSB first, stop; slow phases
  task automatic i2c_addr(input logic [6:0] a);
    @(negedge i_clk_sys);
    o_sda = 1'b0;
    #48 o_sck = 1'b0;
    for (int i = 6; i >= 0; i--) begin
      #48 o_sda = a[i];
      #48 o_sck = 1'b1;
      #48 o_sck = 1'b0;
    end
    #48 o_sda = 1'b0;
    #48 o_sck = 1'b1;
    #48 o_sda = 1'b1;
    // Bus free time, so the next start is not squeezed
    // under the synchroniser's settling window
    #48;
  endtask : i2c_addr
endmodule : hpsel_host_model
`default_nettype wire

// ---- tb_hpsel_top.sv ----
`default_nettype none
// ==========================================================
// Bench for the protocol select block
// ==========================================================
module tb_hpsel_top;
  import hpsel_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned EDGES_TB = 4; // Shortened quota
  logic i_clk_sys, i_reset, i_soft_reset;
  wire logic sck, csb_n, sda; // Pins from the host model
  logic m_i2c, m_i3c, m_spi, en, inv, oe; // Design outputs
  int bad_count, n_tests, seed;
  logic [6:0] a;
  hpsel_host_model hpsel_host_model_inst (.i_clk_sys(i_clk_sys),
    .o_sck(sck), .o_csb_n(csb_n), .o_sda(sda));
  hpsel_top #(.EDGES(EDGES_TB)) hpsel_top_inst (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_soft_reset(i_soft_reset), .i_sck(sck), .i_csb_n(csb_n),
    .i_sda(sda), .o_mode_i2c(m_i2c), .o_mode_i3c(m_i3c),
    .o_mode_spi(m_spi), .o_i2c_i3c_en(en),
    .o_spi_data_invalid(inv), .o_sda_oe(oe));
  // Expected pins: one-hot mode, enable, invalid flag, no drive
  function automatic logic [5:0] exp_st(input hpsel_mode_t m,
      input logic fr);
    exp_st = {m == HPSEL_I2C, m == HPSEL_I3C, m == HPSEL_SPI,
      m != HPSEL_SPI && !fr, m != HPSEL_SPI && fr, 1'b0};
  endfunction : exp_st
  // Verdict and end of run, reached from every path
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  // Bounded poll; synchronisers need a few cycles to settle
  task automatic chk_state(input logic [5:0] exp);
    logic [5:0] seen;
    seen = 6'h00;
    for (int i = 0; i < 12; i++) begin
      @(negedge i_clk_sys);
      seen = {m_i2c, m_i3c, m_spi, en, inv, oe};
      if (seen === exp) break;
    end
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch port_state expected %h seen %h", exp, seen);
    end
  endtask : chk_state
  // One chip-select frame, state checked while it is low
  task automatic frame(input int n, input hpsel_mode_t m);
    hpsel_host_model_inst.cs_set(1'b0);
    chk_state(exp_st(m, 1'b1));
    hpsel_host_model_inst.sck_run(n, seed);
    hpsel_host_model_inst.cs_set(1'b1);
  endtask : frame
  // Random address that is never the broadcast one
  task automatic rnd_addr;
    a = 7'($random(seed));
    if (a == BCAST_ADDR) a = 7'h00;
    hpsel_host_model_inst.i2c_addr(a);
  endtask : rnd_addr
  task automatic soft_rst;
    @(negedge i_clk_sys);
    i_soft_reset = 1'b1;
    @(negedge i_clk_sys);
    i_soft_reset = 1'b0;
  endtask : soft_rst
  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (40000) @(posedge i_clk_sys);
    bad_count++;
    complete_run();
  end
  initial begin
    seed = 57967;
    bad_count = 0;
    n_tests = 0;
    i_reset = 1'b1;
    i_soft_reset = 1'b0;
    repeat (5) @(negedge i_clk_sys);
    i_reset = 1'b0;
    repeat (5) @(negedge i_clk_sys);
    chk_state(exp_st(HPSEL_I2C, 1'b0));
    // Short frames of random length are refused
    for (int k = 0; k < 3; k++) begin
      frame(1 + 32'($unsigned($random(seed))) % (EDGES_TB - 1),
        HPSEL_I2C);
      chk_state(exp_st(HPSEL_I2C, 1'b0));
      rnd_addr();
      chk_state(exp_st(HPSEL_I2C, 1'b0));
    end
    hpsel_host_model_inst.i2c_addr(BCAST_ADDR);
    chk_state(exp_st(HPSEL_I3C, 1'b0));
    rnd_addr();
    chk_state(exp_st(HPSEL_I3C, 1'b0));
    soft_rst();
    chk_state(exp_st(HPSEL_I2C, 1'b0));
    hpsel_host_model_inst.i2c_addr(BCAST_ADDR);
    chk_state(exp_st(HPSEL_I3C, 1'b0));
    // Exactly the quota moves I3C to SPI
    frame(EDGES_TB, HPSEL_I3C);
    chk_state(exp_st(HPSEL_SPI, 1'b0));
    hpsel_host_model_inst.i2c_addr(BCAST_ADDR);
    chk_state(exp_st(HPSEL_SPI, 1'b0));
    frame(EDGES_TB - 1, HPSEL_SPI);
    chk_state(exp_st(HPSEL_SPI, 1'b0));
    // Second hard reset in mid-run
    @(negedge i_clk_sys);
    i_reset = 1'b1;
    repeat (3) @(negedge i_clk_sys);
    i_reset = 1'b0;
    chk_state(exp_st(HPSEL_I2C, 1'b0));
    frame(EDGES_TB + 32'($unsigned($random(seed))) % 8, HPSEL_I2C);
    chk_state(exp_st(HPSEL_SPI, 1'b0));
    soft_rst();
    chk_state(exp_st(HPSEL_I2C, 1'b0));
    complete_run();
  end
endmodule : tb_hpsel_top
`default_nettype wire
